// [include/adc_seq_pkg.sv]
// Constants, carrier types and states for the ADC reading sequencer.
// Assumes a 24-bit register port and a 20 MHz system clock.
// Contract
// - Converter enable bit takes the general ADC out of low power.
// - Writing one to conversion start requests a general-purpose set.
// - Continuous bit repeats general sets; otherwise one set per start.
// - Pending touch start is served before pending general start.
// - General hold pauses the sequencer; host sets it while reading results.
// - General set runs slot zero up to and including its stop slot.
// - Manual indicator bit enables manual LED control when set.
// - Touch enable bit takes the touch path out of low power.
// - Writing one to touch start requests a touchscreen set.
// - Touch continuous bit repeats touch sets; otherwise one per request.
// - Touch hold pauses the sequencer; host sets it while reading results.
// - Touch set runs slot zero through its own independent stop slot.
// - Pen detect bit enables pen detection; host keeps touch enable clear.
// - A programmable delay precedes the first general reading of a set.
// - A programmable delay separates successive general readings.
// - General post-set delay applies only between continuous repetitions.
// - Touch sets use their own pre, inter and post delays.
// - Slots zero to five each have a 4-bit channel select, slot zero lowest; slots six and seven use channel zero.
// - General and touch stop settings are kept separately.
`default_nettype none
package adc_seq_pkg;
    localparam logic [5:0] CTRL_ADDR   = 6'h2B;
    localparam logic [5:0] DELAY_ADDR  = 6'h2C;
    localparam logic [5:0] SELECT_ADDR = 6'h2D;
    localparam logic [23:0] REG_RESET  = 24'h000000;
    localparam int CONV_EN_BIT    = 0;
    localparam int CONV_START_BIT = 1;
    localparam int CONV_CONT_BIT  = 2;
    localparam int CONV_HOLD_BIT  = 3;
    localparam int CONV_STOP_LSB  = 4;
    localparam int LED_MANUAL_BIT = 8;
    localparam int TOUCH_EN_BIT    = 12;
    localparam int TOUCH_START_BIT = 13;
    localparam int TOUCH_CONT_BIT  = 14;
    localparam int TOUCH_HOLD_BIT  = 15;
    localparam int TOUCH_STOP_LSB  = 16;
    localparam int PEN_DETECT_BIT  = 20;
    localparam int CONV_PRE_LSB    = 0;
    localparam int CONV_INTER_LSB  = 4;
    localparam int CONV_POST_LSB   = 8;
    localparam int TOUCH_PRE_LSB   = 12;
    localparam int TOUCH_INTER_LSB = 16;
    localparam int TOUCH_POST_LSB  = 20;
    localparam int SELECT_SLOTS    = 6;
    // One delay step is 1 us
    localparam int CLK_PERIOD_NS   = 50;
    localparam int DELAY_STEP_NS   = 1000;
    localparam logic [9:0] DELAY_STEP_CYCLES = 10'(DELAY_STEP_NS / CLK_PERIOD_NS);

    typedef struct packed {
        logic       touch;
        logic [2:0] slot;
        logic [3:0] channel;
    } conv_cmd_t;

    typedef struct packed {
        logic       touch;
        logic [2:0] slot;
        logic [9:0] data;
    } result_wr_t;

    typedef enum logic [2:0] {S_IDLE, S_PRE, S_CONV, S_WAIT, S_INTER, S_POST} seq_state_t;
endpackage
`default_nettype wire

// [hw/adc_touch_read_sequencer.sv]
// Register file and reading sequencer for general and touchscreen ADC sets.
// Assumes the serial bus front end delivers one-cycle read and write strobes,
// and the analog converter answers each request with a one-cycle done pulse.
`timescale 1ns/1ns
`default_nettype none
module adc_touch_read_sequencer (
    input  wire logic                     clk_sys,
    input  wire logic                     rst_n,
    input  wire logic                     digital_reset_n,
    input  wire logic [5:0]               reg_addr,
    input  wire logic [23:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic [23:0]                   reg_rdata,
    output logic                          conv_power_enable,
    output logic                          touch_power_enable,
    output logic                          pen_detect_enable,
    output logic                          manual_led_control,
    output logic                          conv_req,
    output adc_seq_pkg::conv_cmd_t        conv_cmd,
    input  wire logic                     conv_done,
    input  wire logic [9:0]               conv_data,
    output logic                          result_we,
    output adc_seq_pkg::result_wr_t       result_wr,
    output logic                          seq_busy
);
    import adc_seq_pkg::*;

    logic [23:0] ctrl_reg, ctrl_next;
    logic [23:0] delay_reg;
    logic [23:0] select_reg;
    logic [23:0] rdata_reg;
    seq_state_t  state_reg, state_next;
    logic [9:0]  cnt_reg, cnt_next;
    logic [2:0]  slot_reg, slot_next;
    logic        touch_reg, touch_next;
    logic        req_reg;
    conv_cmd_t   cmd_reg;
    logic        we_reg;
    result_wr_t  wr_reg;
    logic        busy_reg;

    function automatic logic [9:0] step_cycles(input logic [23:0] r, input int lsb);
        step_cycles = 10'(r[lsb +: 4]) * DELAY_STEP_CYCLES;
    endfunction

    function automatic logic [3:0] slot_channel(input logic [23:0] r, input logic [2:0] s);
        slot_channel = (32'(s) < SELECT_SLOTS) ? r[4 * s +: 4] : 4'h0;
    endfunction

    wire wr_ctrl   = reg_wr && (reg_addr == CTRL_ADDR);
    wire wr_delay  = reg_wr && (reg_addr == DELAY_ADDR);
    wire wr_select = reg_wr && (reg_addr == SELECT_ADDR);

    wire ad_go = ctrl_reg[CONV_START_BIT] && ctrl_reg[CONV_EN_BIT];
    wire ts_go = ctrl_reg[TOUCH_START_BIT] && ctrl_reg[TOUCH_EN_BIT];
    wire pick_touch = ts_go;
    wire [2:0] stop_slot = touch_reg ? ctrl_reg[TOUCH_STOP_LSB +: 3]
                                     : ctrl_reg[CONV_STOP_LSB +: 3];
    wire cont_act = touch_reg ? ctrl_reg[TOUCH_CONT_BIT] : ctrl_reg[CONV_CONT_BIT];
    wire hold_act = touch_reg ? ctrl_reg[TOUCH_HOLD_BIT] : ctrl_reg[CONV_HOLD_BIT];
    wire en_act   = touch_reg ? ctrl_reg[TOUCH_EN_BIT] : ctrl_reg[CONV_EN_BIT];
    wire [9:0] inter_cycles = touch_reg ? step_cycles(delay_reg, TOUCH_INTER_LSB)
                                        : step_cycles(delay_reg, CONV_INTER_LSB);
    wire [9:0] post_cycles  = touch_reg ? step_cycles(delay_reg, TOUCH_POST_LSB)
                                        : step_cycles(delay_reg, CONV_POST_LSB);
    wire [9:0] pre_cycles   = touch_reg ? step_cycles(delay_reg, TOUCH_PRE_LSB)
                                        : step_cycles(delay_reg, CONV_PRE_LSB);
    wire start_set = (state_reg == S_IDLE) && (ad_go || ts_go);
    wire issue     = (state_reg == S_CONV) && !hold_act && en_act;
    wire last_slot = slot_reg == stop_slot;
    wire [23:0] rd_mux = (reg_addr == CTRL_ADDR)   ? ctrl_reg :
                         (reg_addr == DELAY_ADDR)  ? delay_reg :
                         (reg_addr == SELECT_ADDR) ? select_reg : 24'h000000;

    // Start bits self-clear when their set is taken; a write of one in the
    // same cycle wins so that a fresh request is never lost.
    always_comb begin
        ctrl_next = wr_ctrl ? reg_wdata : ctrl_reg;
        if (start_set && pick_touch && !(wr_ctrl && reg_wdata[TOUCH_START_BIT])) begin
            ctrl_next[TOUCH_START_BIT] = 1'b0;
        end
        if (start_set && !pick_touch && !(wr_ctrl && reg_wdata[CONV_START_BIT])) begin
            ctrl_next[CONV_START_BIT] = 1'b0;
        end
    end

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        slot_next  = slot_reg;
        touch_next = touch_reg;
        unique case (state_reg)
            S_IDLE: begin
                if (start_set) begin
                    touch_next = pick_touch;
                    slot_next  = 3'h0;
                    cnt_next   = pick_touch ? step_cycles(delay_reg, TOUCH_PRE_LSB)
                                            : step_cycles(delay_reg, CONV_PRE_LSB);
                    state_next = S_PRE;
                end
            end
            S_PRE, S_INTER, S_POST: begin
                if (!hold_act) begin
                    if (cnt_reg == 10'h000) begin
                        state_next = (state_reg == S_POST) ? S_PRE : S_CONV;
                        cnt_next   = pre_cycles;
                    end else begin
                        cnt_next = cnt_reg - 10'h001;
                    end
                end
            end
            S_CONV: begin
                if (!en_act) begin
                    state_next = S_IDLE;
                end else if (issue) begin
                    state_next = S_WAIT;
                end
            end
            S_WAIT: begin
                if (conv_done) begin
                    if (!last_slot) begin
                        slot_next  = slot_reg + 3'h1;
                        cnt_next   = inter_cycles;
                        state_next = S_INTER;
                    end else if (cont_act) begin
                        slot_next  = 3'h0;
                        cnt_next   = post_cycles;
                        state_next = S_POST;
                    end else begin
                        state_next = S_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg   <= REG_RESET;
            delay_reg  <= REG_RESET;
            select_reg <= REG_RESET;
        end else if (!digital_reset_n) begin
            ctrl_reg   <= REG_RESET;
            delay_reg  <= REG_RESET;
            select_reg <= REG_RESET;
        end else begin
            ctrl_reg   <= ctrl_next;
            delay_reg  <= wr_delay ? reg_wdata : delay_reg;
            select_reg <= wr_select ? reg_wdata : select_reg;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= S_IDLE;
            cnt_reg   <= 10'h000;
            slot_reg  <= 3'h0;
            touch_reg <= 1'b0;
            busy_reg  <= 1'b0;
        end else if (!digital_reset_n) begin
            state_reg <= S_IDLE;
            cnt_reg   <= 10'h000;
            slot_reg  <= 3'h0;
            touch_reg <= 1'b0;
            busy_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            slot_reg  <= slot_next;
            touch_reg <= touch_next;
            // Taken from the next state so busy changes with the state flop
            busy_reg  <= (state_next != S_IDLE);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            req_reg   <= 1'b0;
            cmd_reg   <= '0;
            we_reg    <= 1'b0;
            wr_reg    <= '0;
            rdata_reg <= 24'h000000;
        end else begin
            req_reg <= issue && digital_reset_n;
            if (issue) begin
                cmd_reg <= '{touch: touch_reg, slot: slot_reg,
                             channel: slot_channel(select_reg, slot_reg)};
            end
            // Results land only in the slot just converted
            we_reg <= (state_reg == S_WAIT) && conv_done && digital_reset_n;
            if ((state_reg == S_WAIT) && conv_done) begin
                wr_reg <= '{touch: touch_reg, slot: slot_reg, data: conv_data};
            end
            if (reg_rd) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    assign reg_rdata          = rdata_reg;
    assign conv_power_enable  = ctrl_reg[CONV_EN_BIT];
    assign touch_power_enable = ctrl_reg[TOUCH_EN_BIT];
    assign pen_detect_enable  = ctrl_reg[PEN_DETECT_BIT];
    assign manual_led_control = ctrl_reg[LED_MANUAL_BIT];
    assign conv_req           = req_reg;
    assign conv_cmd           = cmd_reg;
    assign result_we          = we_reg;
    assign result_wr          = wr_reg;
    assign seq_busy           = busy_reg;

    a_touch_first: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (start_set && ts_go && ad_go && digital_reset_n) |=> touch_reg)
        else $error("touch request not served first");
    a_req_power: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (conv_req && !conv_cmd.touch) |-> $past(ctrl_reg[CONV_EN_BIT]))
        else $error("conversion issued while converter in low power");
    a_set_from_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (start_set && digital_reset_n) |=> (slot_reg == 3'h0) && (state_reg == S_PRE))
        else $error("set did not begin at slot zero");
    a_slot_bound: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (we_reg && !wr_reg.touch) |-> wr_reg.slot <= $past(ctrl_reg[CONV_STOP_LSB +: 3]))
        else $error("result written beyond stop slot");
    a_hold_pause: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ((state_reg == S_CONV) && hold_act) |=> !conv_req)
        else $error("conversion issued during hold");
    a_single_end: assert property (@(posedge clk_sys) disable iff (!rst_n || !digital_reset_n)
        ((state_reg == S_WAIT) && conv_done && last_slot && !cont_act) |=> (state_reg == S_IDLE))
        else $error("single set did not end at stop slot");
    a_wrap_post: assert property (@(posedge clk_sys) disable iff (!rst_n || !digital_reset_n)
        ((state_reg == S_WAIT) && conv_done && last_slot && cont_act)
        |=> (state_reg == S_POST) && (cnt_reg == $past(post_cycles)))
        else $error("continuous wrap skipped post delay");
    a_pre_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (start_set && !ts_go && (delay_reg[CONV_PRE_LSB +: 4] == 4'h0)
         && !ctrl_reg[CONV_HOLD_BIT] && digital_reset_n && !reg_wr) |=> ##2 conv_req)
        else $error("zero pre-delay not honoured");
    a_reset_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !digital_reset_n |=> (ctrl_reg == 24'h000000) && (delay_reg == 24'h000000)
                             && (select_reg == 24'h000000))
        else $error("digital reset left fields set");

    // Power, start requests and priority
    a_idle_no_power: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ((state_reg == S_IDLE) && !ctrl_reg[CONV_EN_BIT] && !ts_go) |=> !seq_busy)
        else $error("set started while converter in low power");
    a_touch_power: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (conv_req && conv_cmd.touch) |-> $past(ctrl_reg[TOUCH_EN_BIT]))
        else $error("touch conversion issued while touch path in low power");
    a_conv_start_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (start_set && !ts_go && !wr_ctrl && digital_reset_n) |=> !ctrl_reg[CONV_START_BIT])
        else $error("general start request not taken");
    a_touch_start_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (start_set && ts_go && !wr_ctrl && digital_reset_n) |=> !ctrl_reg[TOUCH_START_BIT])
        else $error("touch start request not taken");

    // Delays and hold
    a_conv_pre: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (start_set && !ts_go && digital_reset_n)
        |=> (cnt_reg == 10'($past(delay_reg[CONV_PRE_LSB +: 4])) * DELAY_STEP_CYCLES))
        else $error("general pre-delay not loaded");
    a_touch_pre: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (start_set && ts_go && digital_reset_n)
        |=> (cnt_reg == 10'($past(delay_reg[TOUCH_PRE_LSB +: 4])) * DELAY_STEP_CYCLES))
        else $error("touch pre-delay not loaded");
    a_inter_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ((state_reg == S_WAIT) && conv_done && !last_slot && digital_reset_n)
        |=> (state_reg == S_INTER) && (slot_reg == $past(slot_reg) + 3'h1)
            && (cnt_reg == $past(inter_cycles)))
        else $error("inter-reading delay not loaded");
    a_post_to_pre: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ((state_reg == S_POST) && !hold_act && (cnt_reg == 10'h000) && digital_reset_n)
        |=> (state_reg == S_PRE) && (cnt_reg == $past(pre_cycles)))
        else $error("repetition skipped pre-delay");
    a_hold_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (((state_reg == S_PRE) || (state_reg == S_INTER) || (state_reg == S_POST)) && hold_act && digital_reset_n)
        |=> $stable(cnt_reg) && $stable(state_reg))
        else $error("delay advanced during hold");

    // Slots and results
    a_touch_slot_bound: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (we_reg && wr_reg.touch) |-> wr_reg.slot <= $past(ctrl_reg[TOUCH_STOP_LSB +: 3]))
        else $error("touch result written beyond stop slot");
    a_wrap_slot: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ((state_reg == S_WAIT) && conv_done && last_slot && cont_act && digital_reset_n) |=> (slot_reg == 3'h0))
        else $error("repetition did not restart at slot zero");
    a_slot0_channel: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (conv_req && (conv_cmd.slot == 3'h0)) |-> (conv_cmd.channel == $past(select_reg[3:0])))
        else $error("slot zero used wrong channel select");
    a_slot5_channel: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (conv_req && (conv_cmd.slot == 3'h5)) |-> (conv_cmd.channel == $past(select_reg[23:20])))
        else $error("slot five used wrong channel select");
    a_done_result: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ((state_reg == S_WAIT) && conv_done && digital_reset_n)
        |=> result_we && (result_wr.slot == $past(slot_reg)) && (result_wr.data == $past(conv_data)))
        else $error("completed reading not written to its slot");
    a_req_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
        conv_req |=> !conv_req)
        else $error("back-to-back conversion requests");
    a_we_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
        result_we |=> !result_we)
        else $error("result written twice for one reading");
    a_reset_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !digital_reset_n |=> !seq_busy && !conv_req && !result_we)
        else $error("digital reset left sequencer running");
endmodule
`default_nettype wire

// [testbench/adc_conv_model.sv]
// Behavioural analog converter that answers the sequencer's requests.
// Assumes one outstanding request; the answer latency is set by the bench.
`timescale 1ns/1ns
`default_nettype none
module adc_conv_model (
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    input  wire logic [3:0]             latency,
    input  wire logic                   conv_req,
    input  wire adc_seq_pkg::conv_cmd_t conv_cmd,
    output logic                        conv_done,
    output logic [9:0]                  conv_data
);
    import adc_seq_pkg::*;
    logic [3:0] count_reg;
    logic [9:0] sample_reg;
    // Result encodes slot and channel so the bench can tell where it landed
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count_reg  <= 4'h0;
            sample_reg <= 10'h000;
            conv_done  <= 1'b0;
        end else begin
            if (conv_req) begin
                count_reg  <= latency;
                sample_reg <= {conv_cmd.touch, conv_cmd.slot, 2'b01, conv_cmd.channel};
            end else if (count_reg != 4'h0) begin
                count_reg <= count_reg - 4'h1;
            end
            conv_done <= (count_reg == 4'h1) && !conv_req;
        end
    end
    // Outside the answer cycle the data is not valid, so show the inverse
    assign conv_data = conv_done ? sample_reg : ~sample_reg;
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for the ADC reading sequencer with a converter model.
// Assumes single-cycle register strobes and a delay step of 20 clock cycles.
`timescale 1ns/1ns
`default_nettype none
`define CHECK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; $display("ERROR at %0t: got %0h expected %0h", $time, (g), (e)); end end
module tb_top;
    import adc_seq_pkg::*;
    logic        clk_sys, rst_n, digital_reset_n, reg_wr, reg_rd, conv_req, conv_done, result_we, seq_busy;
    logic        conv_power_enable, touch_power_enable, pen_detect_enable, manual_led_control;
    logic [5:0]  reg_addr;
    logic [23:0] reg_wdata, reg_rdata, rd;
    logic [9:0]  conv_data;
    logic [3:0]  latency;
    conv_cmd_t   conv_cmd;
    result_wr_t  result_wr;
    conv_cmd_t   rq_q[$];
    result_wr_t  wr_q[$];
    int          rq_t[$], wr_t[$], cyc, t_w, mismatches, compares, lat0, latt, gap0, gp[2];

    adc_touch_read_sequencer u_adc_touch_read_sequencer (.clk_sys(clk_sys), .rst_n(rst_n),
        .digital_reset_n(digital_reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_power_enable(conv_power_enable),
        .touch_power_enable(touch_power_enable), .pen_detect_enable(pen_detect_enable),
        .manual_led_control(manual_led_control), .conv_req(conv_req), .conv_cmd(conv_cmd),
        .conv_done(conv_done), .conv_data(conv_data), .result_we(result_we), .result_wr(result_wr),
        .seq_busy(seq_busy));
    adc_conv_model u_adc_conv_model (.clk_sys(clk_sys), .rst_n(rst_n), .latency(latency),
        .conv_req(conv_req), .conv_cmd(conv_cmd), .conv_done(conv_done), .conv_data(conv_data));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (conv_req === 1'b1) begin
            rq_q.push_back(conv_cmd);
            rq_t.push_back(cyc);
        end
        if (result_we === 1'b1) begin
            wr_q.push_back(result_wr);
            wr_t.push_back(cyc);
        end
    end

    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [5:0] a, input logic [23:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick(1);
        reg_wr = 1'b0;
        tick(1);
    endtask
    task automatic rdreg(input logic [5:0] a);
        reg_addr = a;
        reg_rd = 1'b1;
        tick(1);
        reg_rd = 1'b0;
        rd = reg_rdata;
        tick(1);
    endtask
    // Write a control word, then wait for n requests and results, and for idle if asked
    task automatic run(input logic [23:0] ctrl, input int n, input bit to_idle);
        int k;
        rq_q.delete();
        wr_q.delete();
        rq_t.delete();
        wr_t.delete();
        t_w = cyc;
        wr(CTRL_ADDR, ctrl);
        for (k = 0; k < 8000; k++) begin
            if (rq_q.size() >= n && wr_q.size() >= n && (!to_idle || seq_busy === 1'b0)) break;
            tick(1);
        end
        if (k == 8000) begin
            mismatches++;
            report_and_stop();
        end
    endtask
    task automatic chk_slots(input int base, input int n, input logic t);
        int j;
        logic [7:0]  ec;
        logic [13:0] ew;
        for (j = 0; j < n; j++) begin
            ec = {t, 3'(j), 4'(j + 1)};
            ew = {ec[7:4], ec[7:4], 2'b01, ec[3:0]};
            `CHECK(rq_q[base + j], ec)
            `CHECK(wr_q[base + j], ew)
        end
    endtask

    task automatic t_regs;
        int i;
        logic [5:0] addrs[4] = '{CTRL_ADDR, DELAY_ADDR, SELECT_ADDR, 6'h2E};
        for (i = 0; i < 4; i++) begin
            rdreg(addrs[i]);
            `CHECK(rd, REG_RESET)
        end
        // Pen detection only with the touch path left in low power
        wr(CTRL_ADDR, 24'h170170);
        rdreg(CTRL_ADDR);
        `CHECK(rd, 24'h170170)
        `CHECK({manual_led_control, pen_detect_enable, conv_power_enable, touch_power_enable}, 4'hC)
        wr(DELAY_ADDR, 24'hFEDCBA);
        wr(6'h2E, 24'hFFFFFF);
        rdreg(DELAY_ADDR);
        `CHECK(rd, 24'hFEDCBA)
        wr(CTRL_ADDR, 24'h001001);
        `CHECK({conv_power_enable, touch_power_enable}, 2'b11)
        rq_q.delete();
        wr(CTRL_ADDR, 24'h000002);
        // Outlasts the programmed pre-delay so a wrongly taken start would show
        tick(260);
        `CHECK(rq_q.size(), 0)
        wr(SELECT_ADDR, 24'h654321);
        digital_reset_n = 1'b0;
        tick(1);
        digital_reset_n = 1'b1;
        tick(1);
        for (i = 0; i < 3; i++) begin
            rdreg(addrs[i]);
            `CHECK(rd, REG_RESET)
        end
    endtask

    task automatic t_general;
        wr(SELECT_ADDR, 24'h654321);
        latency = 4'd9;
        run(24'h000053, 6, 1'b1);
        chk_slots(0, 6, 1'b0);
        `CHECK(wr_q.size(), 6)
        lat0 = rq_t[0] - t_w;
        gap0 = rq_t[1] - wr_t[0];
        rdreg(CTRL_ADDR);
        `CHECK(rd, 24'h000051)
        latency = 4'd2;
        wr(DELAY_ADDR, 24'h000001);
        run(24'h000003, 1, 1'b1);
        `CHECK(rq_t[0] - t_w, lat0 + 20)
        wr(DELAY_ADDR, 24'h000010);
        run(24'h000013, 2, 1'b1);
        `CHECK(rq_t[1] - wr_t[0], gap0 + 20)
    endtask

    task automatic t_priority;
        wr(DELAY_ADDR, 24'h000000);
        run(24'h013003, 3, 1'b1);
        chk_slots(0, 2, 1'b1);
        chk_slots(2, 1, 1'b0);
        latt = rq_t[0] - t_w;
        wr(DELAY_ADDR, 24'h001000);
        run(24'h003000, 1, 1'b1);
        `CHECK(rq_t[0] - t_w, latt + 20)
    endtask

    task automatic t_cont;
        int k;
        int p;
        for (k = 0; k < 2; k++) begin
            for (p = 0; p < 2; p++) begin
                wr(DELAY_ADDR, 24'(p) << (k ? 20 : 8));
                run(k ? 24'h007000 : 24'h000007, 3, 1'b0);
                gp[p] = rq_t[2] - rq_t[1];
                `CHECK(rq_q[2].touch, 1'(k))
                run(k ? 24'h001000 : 24'h000001, 0, 1'b1);
                tick(60);
                `CHECK(seq_busy, 1'b0)
            end
            `CHECK(gp[1], gp[0] + 20)
        end
    endtask

    task automatic t_hold;
        int k;
        wr(DELAY_ADDR, 24'h000000);
        for (k = 0; k < 2; k++) begin
            // Host holds the sequencer as it would while reading results
            run(k ? 24'h00B000 : 24'h00000B, 0, 1'b0);
            tick(100);
            `CHECK(rq_q.size(), 0)
            run(k ? 24'h001000 : 24'h000001, 1, 1'b1);
            `CHECK(rq_q[0].touch, 1'(k))
        end
    endtask

    initial begin
        rst_n = 1'b0;
        digital_reset_n = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 6'h00;
        reg_wdata = 24'h000000;
        latency = 4'd2;
        tick(6);
        rst_n = 1'b1;
        tick(2);
        t_regs();
        $display("register test done");
        t_general();
        $display("general set test done");
        t_priority();
        $display("priority test done");
        t_cont();
        $display("continuous test done");
        t_hold();
        $display("hold test done");
        report_and_stop();
    end
endmodule
`default_nettype wire
